// ### etc_pin_model.sv
/*
 * etc_pin_model: far side of the two channel pins, one outside driver per pin.
 * Assumes the timer drives a pin only while its enable is high; otherwise the
 * line shows the outside level that the bench sets.
 */
`timescale 1ns/10ps
module etc_pin_model (
	input  wire logic a_pin_i,
	input  wire logic a_oe_i,
	input  wire logic a_ext_i,
	output logic      a_line_o,
	input  wire logic b_pin_i,
	input  wire logic b_oe_i,
	input  wire logic b_ext_i,
	output logic      b_line_o
);
	// the outside driver never lets go, so a released line never floats
	assign a_line_o = a_oe_i ? a_pin_i : a_ext_i;
	assign b_line_o = b_oe_i ? b_pin_i : b_ext_i;
endmodule : etc_pin_model

// ### etc_pkg.sv
/*
 * etc_pkg: register indices, field layouts, reset values and mode encodings
 * for the enhanced timer control block.
 * Assumes an 8-bit register port with a 4-bit register index.
 */
package etc_pkg;

	// register indices on the plain register port
	localparam logic [3:0] REG_TIMER_CTRL   = 4'h0;
	localparam logic [3:0] REG_CHAN_A_CTRL  = 4'h1;
	localparam logic [3:0] REG_CHAN_B_CTRL  = 4'h2;
	localparam logic [3:0] REG_COUNT_LO     = 4'h3;
	localparam logic [3:0] REG_COUNT_HI     = 4'h4;
	localparam logic [3:0] REG_CMP_A_LO     = 4'h5;
	localparam logic [3:0] REG_CMP_A_HI     = 4'h6;
	localparam logic [3:0] REG_CMP_B_LO     = 4'h7;
	localparam logic [3:0] REG_CMP_B_HI     = 4'h8;

	localparam int          CNT_W           = 10;
	localparam logic [7:0]  CTRL_RESET      = 8'h00;
	localparam logic [9:0]  CNT_RESET       = 10'h000;
	localparam logic [6:0]  PERIOD_LOW_ONES = 7'h7f;
	localparam int          DIR_BIT         = 1;

	// channel mode field
	localparam logic [1:0] MODE_COMPARE = 2'h0;
	localparam logic [1:0] MODE_CAPTURE = 2'h1;
	localparam logic [1:0] MODE_PWM     = 2'h2;
	localparam logic [1:0] MODE_TIMER   = 2'h3;

	// output function field, per mode
	localparam logic [1:0] CMP_NONE     = 2'h0;
	localparam logic [1:0] CMP_LOW      = 2'h1;
	localparam logic [1:0] CMP_HIGH     = 2'h2;
	localparam logic [1:0] CMP_TOGGLE   = 2'h3;
	localparam logic [1:0] PWM_INACTIVE = 2'h0;
	localparam logic [1:0] PWM_ACTIVE   = 2'h1;
	localparam logic [1:0] PWM_WAVE     = 2'h2;
	localparam logic [1:0] PWM_SPULSE   = 2'h3;
	localparam logic [1:0] CAP_RISE     = 2'h0;
	localparam logic [1:0] CAP_FALL     = 2'h1;
	localparam logic [1:0] CAP_BOTH     = 2'h2;
	localparam logic [1:0] CAP_OFF      = 2'h3;

	// pwm alignment field
	localparam logic [1:0] ALIGN_EDGE   = 2'h0;
	localparam logic [1:0] ALIGN_UP     = 2'h1;
	localparam logic [1:0] ALIGN_DOWN   = 2'h2;
	localparam logic [1:0] ALIGN_BOTH   = 2'h3;

	typedef struct packed {
		logic       counter_pause_bit;
		logic [2:0] clock_select;
		logic       counter_run_bit;
		logic [2:0] period_match_code;
	} etc_timer_ctrl_t;

	// low_bits: channel a {direction (read only), counter_clear_select};
	// channel b pwm_alignment_field
	typedef struct packed {
		logic [1:0] mode_field;
		logic [1:0] output_function;
		logic       initial_level;
		logic       invert;
		logic [1:0] low_bits;
	} etc_chan_ctrl_t;

endpackage : etc_pkg

// ### etc_timer.sv
/*
 * etc_timer: 10-bit two-channel enhanced timer, control registers, counter,
 * period comparator and channel pin logic in one module.
 * Assumes the register port master of the same clock and pins from outside
 * the clock domain; channel pin inputs are synchronised here.
 */
// Overview of operation
// [R1] run bit rising clears counter; falling holds counter until next rise
// [R2] run bit low stops counting and powers the timer off
// [R3] compare mode: run bit rising restores each pin to its initial level
// [R4] period code compared with counter bits 9..7; code 000 means 1024 clocks
// [R5] clear select 0 clears on period match, 1 on channel A; never B
// [R6] overflow clearing only with clear select 0 and period code zero
// [R7] clear select ignored in PWM, single pulse and capture modes
// [R8] two-bit mode: compare, capture, PWM/single pulse, timer/counter
// [R9] software stops the timer before changing modes; timer mode disables pins
// [R10] compare mode function: none, drive low, drive high, toggle on match
// [R11] PWM function: force inactive, force active, PWM wave, single pulse
// [R12] capture function: rising, falling, both edges, disabled
// [R13] initial level bit: compare start level, PWM active level; unused in timer
// [R14] compare: requested level equal to initial level gives no pin change
// [R15] invert bit inverts final channel output; unused in timer mode
// [R16] read-only direction flag: 0 counting up, 1 counting down
// [R17] software changes PWM function only while the timer is off
// [R18] alignment: edge, centre up match, centre down match, centre both
// [R19] channel control fields reset to zero; direction read only, rest read/write
// [R20] 10-bit up/down counter; 10-bit compare values against all bits
// [R21] pause holds the counter powered; clearing resumes from held value
// [R22] channel B compare action follows its own comparator match
// [R23] both channels share one mode; mixed mode pairs unsupported
`timescale 1ns/10ps
module etc_timer (
	input  wire logic       mclk_i,
	input  wire logic       reset_i,
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	input  wire logic       chan_a_pin_i,
	output logic            chan_a_pin_o,
	output logic            chan_a_pin_oe_o,
	input  wire logic       chan_b_pin_i,
	output logic            chan_b_pin_o,
	output logic            chan_b_pin_oe_o
);

	etc_pkg::etc_timer_ctrl_t ctrl_q;
	etc_pkg::etc_chan_ctrl_t  chan_q [2];
	logic [9:0]               cnt_q;
	logic                     dir_q;
	logic [9:0]               cmp_q [2];
	logic                     run_prev_q;
	logic [1:0]               sync1_q;
	logic [1:0]               sync2_q;
	logic [1:0]               pin_prev_q;
	logic [1:0]               level_q;
	logic [1:0]               pin_q;
	logic [1:0]               oe_q;
	logic [7:0]               rdata_q;

	logic       run;
	logic       counting;
	logic       run_rise;
	logic [1:0] mode_a;
	logic [2:0] code_m1;
	logic [9:0] top;
	logic       p_hit;
	logic [1:0] match;
	logic [1:0] cap;
	logic       centre;
	logic       clr_sel;
	logic       sp_stop;
	logic       ctrl_wr;
	logic [7:0] rd_mux;

	assign run      = ctrl_q.counter_run_bit;
	assign counting = run & ~ctrl_q.counter_pause_bit; // R2 R21
	assign run_rise = run & ~run_prev_q;
	assign mode_a   = chan_q[0].mode_field; // R23
	assign ctrl_wr  = wr_i && (addr_i == etc_pkg::REG_TIMER_CTRL);

	// period top is code*128-1, so code 000 wraps at 1023: the overflow case
	assign code_m1 = ctrl_q.period_match_code - 3'h1; // R4
	assign top     = {code_m1, etc_pkg::PERIOD_LOW_ONES}; // R4
	assign p_hit   = (cnt_q == top); // R6
	assign match[0] = (cnt_q == cmp_q[0]); // R20
	assign match[1] = (cnt_q == cmp_q[1]); // R20 R22

	assign centre = (mode_a == etc_pkg::MODE_PWM) &&
		(chan_q[0].output_function != etc_pkg::PWM_SPULSE) &&
		(chan_q[1].low_bits != etc_pkg::ALIGN_EDGE); // R18

	// clear select only steers compare and timer modes
	always_comb
	begin
		unique case (mode_a)
			etc_pkg::MODE_COMPARE,
			etc_pkg::MODE_TIMER:   clr_sel = chan_q[0].low_bits[0] ? match[0] : p_hit; // R5 R6
			etc_pkg::MODE_CAPTURE: clr_sel = p_hit; // R7
			etc_pkg::MODE_PWM:     clr_sel = (chan_q[0].output_function == etc_pkg::PWM_SPULSE) ? 1'b0 : p_hit; // R7
		endcase
	end

	assign sp_stop = counting && (mode_a == etc_pkg::MODE_PWM) &&
		(chan_q[0].output_function == etc_pkg::PWM_SPULSE) && match[0];

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
			ctrl_q <= etc_pkg::CTRL_RESET;
		else if (ctrl_wr)
			ctrl_q <= wdata_i;
		else if (sp_stop)
			ctrl_q.counter_run_bit <= 1'b0;
	end

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
			run_prev_q <= 1'b0;
		else
			run_prev_q <= run;
	end

	// direction bit of channel a register is stored but never read back
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			chan_q[0] <= etc_pkg::CTRL_RESET; // R19
			chan_q[1] <= etc_pkg::CTRL_RESET; // R19
		end
		else if (wr_i && addr_i == etc_pkg::REG_CHAN_A_CTRL)
			chan_q[0] <= wdata_i;
		else if (wr_i && addr_i == etc_pkg::REG_CHAN_B_CTRL)
			chan_q[1] <= wdata_i;
	end

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			cnt_q <= etc_pkg::CNT_RESET;
			dir_q <= 1'b0;
		end
		else if (run_rise)
		begin
			cnt_q <= etc_pkg::CNT_RESET; // R1
			dir_q <= 1'b0;
		end
		else if (counting)
		begin
			if (centre)
			begin
				if (!dir_q && cnt_q == top)
				begin
					dir_q <= 1'b1; // R16
					cnt_q <= cnt_q - 10'h001;
				end
				else if (dir_q && cnt_q == etc_pkg::CNT_RESET)
				begin
					dir_q <= 1'b0; // R16
					cnt_q <= cnt_q + 10'h001;
				end
				else if (dir_q)
					cnt_q <= cnt_q - 10'h001;
				else
					cnt_q <= cnt_q + 10'h001;
			end
			else
			begin
				dir_q <= 1'b0;
				if (clr_sel)
					cnt_q <= etc_pkg::CNT_RESET; // R5
				else
					cnt_q <= cnt_q + 10'h001; // R20
			end
		end
	end

	// pins come from outside the clock domain: two flops before any logic
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			sync1_q    <= 2'h0;
			sync2_q    <= 2'h0;
			pin_prev_q <= 2'h0;
		end
		else
		begin
			sync1_q    <= {chan_b_pin_i, chan_a_pin_i};
			sync2_q    <= sync1_q;
			pin_prev_q <= sync2_q;
		end
	end

	for (genvar i = 0; i < 2; i++)
	begin : g_cap
		always_comb
		begin
			cap[i] = 1'b0;
			if (run && chan_q[i].mode_field == etc_pkg::MODE_CAPTURE)
			begin
				unique case (chan_q[i].output_function)
					etc_pkg::CAP_RISE: cap[i] = sync2_q[i] & ~pin_prev_q[i]; // R12
					etc_pkg::CAP_FALL: cap[i] = ~sync2_q[i] & pin_prev_q[i]; // R12
					etc_pkg::CAP_BOTH: cap[i] = sync2_q[i] ^ pin_prev_q[i]; // R12
					etc_pkg::CAP_OFF:  cap[i] = 1'b0; // R12
				endcase
			end
		end

		// a capture in the same cycle as a software write wins
		always_ff @(posedge mclk_i)
		begin
			if (reset_i)
				cmp_q[i] <= etc_pkg::CNT_RESET;
			else if (cap[i])
				cmp_q[i] <= cnt_q;
			else if (wr_i && addr_i == etc_pkg::REG_CMP_A_LO + 4'(2 * i))
				cmp_q[i][7:0] <= wdata_i;
			else if (wr_i && addr_i == etc_pkg::REG_CMP_A_HI + 4'(2 * i))
				cmp_q[i][9:8] <= wdata_i[1:0];
		end

		// pwm waveform level is kept as "active", mapped to a pin level later
		always_ff @(posedge mclk_i)
		begin
			if (reset_i)
				level_q[i] <= 1'b0;
			else
			begin
				unique case (chan_q[i].mode_field)
					etc_pkg::MODE_COMPARE:
					begin
						if (run_rise)
							level_q[i] <= chan_q[i].initial_level; // R3 R13
						else if (counting && match[i])
						begin
							unique case (chan_q[i].output_function)
								etc_pkg::CMP_NONE: level_q[i] <= level_q[i]; // R10
								etc_pkg::CMP_LOW:
									if (chan_q[i].initial_level)
										level_q[i] <= 1'b0; // R10 R14 R22
								etc_pkg::CMP_HIGH:
									if (!chan_q[i].initial_level)
										level_q[i] <= 1'b1; // R10 R14 R22
								etc_pkg::CMP_TOGGLE: level_q[i] <= ~level_q[i]; // R10 R22
							endcase
						end
					end
					etc_pkg::MODE_PWM:
					begin
						unique case (chan_q[i].output_function)
							etc_pkg::PWM_INACTIVE: level_q[i] <= 1'b0; // R11
							etc_pkg::PWM_ACTIVE:   level_q[i] <= 1'b1; // R11
							etc_pkg::PWM_SPULSE:   level_q[i] <= run & ~sp_stop; // R11
							etc_pkg::PWM_WAVE:
							if (run_rise)
								level_q[i] <= 1'b1;
							else if (counting)
							begin
								if (!centre)
								begin
									if (match[i])
										level_q[i] <= 1'b0; // R18
									else if (clr_sel)
										level_q[i] <= 1'b1; // R18
								end
								else if (match[i] && !dir_q &&
									chan_q[1].low_bits != etc_pkg::ALIGN_DOWN)
									level_q[i] <= 1'b0; // R18
								else if (match[i] && dir_q &&
									chan_q[1].low_bits != etc_pkg::ALIGN_UP)
									level_q[i] <= 1'b1; // R18
								else if (cnt_q == etc_pkg::CNT_RESET &&
									chan_q[1].low_bits == etc_pkg::ALIGN_UP)
									level_q[i] <= 1'b1; // R18
								else if (!dir_q && cnt_q == top &&
									chan_q[1].low_bits == etc_pkg::ALIGN_DOWN)
									level_q[i] <= 1'b0; // R18
							end
						endcase
					end
					etc_pkg::MODE_CAPTURE,
					etc_pkg::MODE_TIMER: level_q[i] <= level_q[i];
				endcase
			end
		end

		always_ff @(posedge mclk_i)
		begin
			if (reset_i)
			begin
				pin_q[i] <= 1'b0;
				oe_q[i]  <= 1'b0;
			end
			else
			begin
				unique case (chan_q[i].mode_field) // R8
					etc_pkg::MODE_COMPARE:
					begin
						pin_q[i] <= level_q[i] ^ chan_q[i].invert; // R15
						oe_q[i]  <= 1'b1;
					end
					etc_pkg::MODE_PWM:
					begin
						pin_q[i] <= (level_q[i] ? chan_q[i].initial_level : ~chan_q[i].initial_level)
							^ chan_q[i].invert; // R13 R15
						oe_q[i]  <= 1'b1;
					end
					etc_pkg::MODE_CAPTURE,
					etc_pkg::MODE_TIMER:
					begin
						pin_q[i] <= 1'b0; // R15
						oe_q[i]  <= 1'b0; // R9
					end
				endcase
			end
		end
	end

	always_comb
	begin
		unique case (addr_i)
			etc_pkg::REG_TIMER_CTRL:  rd_mux = ctrl_q;
			etc_pkg::REG_CHAN_A_CTRL: rd_mux = {chan_q[0][7:2], dir_q, chan_q[0].low_bits[0]}; // R16 R19
			etc_pkg::REG_CHAN_B_CTRL: rd_mux = chan_q[1];
			etc_pkg::REG_COUNT_LO:    rd_mux = cnt_q[7:0];
			etc_pkg::REG_COUNT_HI:    rd_mux = {6'h00, cnt_q[9:8]};
			etc_pkg::REG_CMP_A_LO:    rd_mux = cmp_q[0][7:0];
			etc_pkg::REG_CMP_A_HI:    rd_mux = {6'h00, cmp_q[0][9:8]};
			etc_pkg::REG_CMP_B_LO:    rd_mux = cmp_q[1][7:0];
			etc_pkg::REG_CMP_B_HI:    rd_mux = {6'h00, cmp_q[1][9:8]};
			default:                  rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
			rdata_q <= 8'h00;
		else if (rd_i)
			rdata_q <= rd_mux;
		else
			rdata_q <= 8'h00;
	end

	assign rdata_o         = rdata_q;
	assign chan_a_pin_o    = pin_q[0];
	assign chan_a_pin_oe_o = oe_q[0];
	assign chan_b_pin_o    = pin_q[1];
	assign chan_b_pin_oe_o = oe_q[1];

	a_run_rise_clear: assert property ( // R1
		@(posedge mclk_i) disable iff (reset_i) run_rise |=> cnt_q == 10'h000)
		else $error("counter not cleared on run rise");

	a_stop_hold: assert property ( // R2
		@(posedge mclk_i) disable iff (reset_i) (!counting && !run_rise) |=> $stable(cnt_q))
		else $error("counter moved while stopped or paused");

	a_period_clear: assert property ( // R4
		@(posedge mclk_i) disable iff (reset_i)
		(counting && !run_rise && !centre && clr_sel) |=> cnt_q == 10'h000)
		else $error("counter not cleared on selected match");

	a_dir_readback: assert property ( // R16
		@(posedge mclk_i) disable iff (reset_i)
		(rd_i && addr_i == etc_pkg::REG_CHAN_A_CTRL) |=> rdata_o[etc_pkg::DIR_BIT] == $past(dir_q))
		else $error("direction flag read back wrong");

	a_centre_turn: assert property ( // R18
		@(posedge mclk_i) disable iff (reset_i)
		(counting && !run_rise && centre && !dir_q && cnt_q == top) ##1 counting [*2] |-> dir_q)
		else $error("centre count did not turn at top");

	a_init_restore: assert property ( // R3
		@(posedge mclk_i) disable iff (reset_i)
		(run_rise && chan_q[0].mode_field == etc_pkg::MODE_COMPARE) |=> level_q[0] == $past(chan_q[0].initial_level))
		else $error("pin level not restored on run rise");

	a_toggle_match: assert property ( // R10
		@(posedge mclk_i) disable iff (reset_i)
		(counting && !run_rise && match[1] && chan_q[1].mode_field == etc_pkg::MODE_COMPARE &&
		chan_q[1].output_function == etc_pkg::CMP_TOGGLE) |=> level_q[1] != $past(level_q[1]))
		else $error("toggle on match missing");

	a_same_level: assert property ( // R14
		@(posedge mclk_i) disable iff (reset_i)
		(counting && !run_rise && match[0] && chan_q[0].mode_field == etc_pkg::MODE_COMPARE &&
		chan_q[0].output_function == etc_pkg::CMP_LOW && !chan_q[0].initial_level) |=> $stable(level_q[0]))
		else $error("pin changed though level equals initial");

	a_invert_out: assert property ( // R15
		@(posedge mclk_i) disable iff (reset_i)
		(chan_q[1].mode_field == etc_pkg::MODE_COMPARE) |=> chan_b_pin_o == ($past(level_q[1]) ^ $past(chan_q[1].invert)))
		else $error("output polarity wrong");

	a_timer_no_drive: assert property ( // R9
		@(posedge mclk_i) disable iff (reset_i)
		(chan_q[1].mode_field == etc_pkg::MODE_TIMER) |=> !chan_b_pin_oe_o)
		else $error("pin driven in timer mode");

	a_capture_load: assert property ( // R12
		@(posedge mclk_i) disable iff (reset_i) cap[0] |=> cmp_q[0] == $past(cnt_q))
		else $error("capture did not load counter value");

	a_pulse_stop: assert property ( // R11
		@(posedge mclk_i) disable iff (reset_i) (sp_stop && !ctrl_wr) |=> !run)
		else $error("single pulse did not stop the timer");

endmodule : etc_timer

// ### etc_timer_tb.sv
/*
 * etc_timer_tb: self-checking bench for the enhanced timer control block.
 * Assumes the pin model resolves each channel line and feeds it back as input.
 */
`timescale 1ns/10ps
module etc_timer_tb;
	logic       mclk_i   = 1'b0;
	logic       reset_i  = 1'b1;
	logic [3:0] addr_i   = 4'h0;
	logic [7:0] wdata_i  = 8'h00;
	logic       wr_i     = 1'b0;
	logic       rd_i     = 1'b0;
	logic       ext_a    = 1'b0;
	logic       ext_b    = 1'b0;
	logic [7:0] rdata_o;
	logic       a_o, a_oe, a_line, b_o, b_oe, b_line;
	logic [7:0] v, u;
	logic [1:0] f;
	logic       lv;
	int         errors   = 0;
	int         n_checks = 0;

	etc_timer DUT (
		.mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.chan_a_pin_i(a_line), .chan_a_pin_o(a_o), .chan_a_pin_oe_o(a_oe),
		.chan_b_pin_i(b_line), .chan_b_pin_o(b_o), .chan_b_pin_oe_o(b_oe)
	);
	etc_pin_model pins (
		.a_pin_i(a_o), .a_oe_i(a_oe), .a_ext_i(ext_a), .a_line_o(a_line),
		.b_pin_i(b_o), .b_oe_i(b_oe), .b_ext_i(ext_b), .b_line_o(b_line)
	);

	always #12.5 mclk_i = ~mclk_i;

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// ends 1 ns past the edge so registered outputs have settled
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask : cyc

	// a spare cycle after each strobe keeps one assignment per time step
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		@(posedge mclk_i);
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
		@(posedge mclk_i);
	endtask : rd

	task automatic t_regs;
		for (int i = 0; i < 3; i++)
		begin
			rd(4'(i), v);
			check(v, etc_pkg::CTRL_RESET);
		end
		rd(4'hf, v);
		check(v, 8'h00);
		wr(etc_pkg::REG_CHAN_A_CTRL, 8'hff);
		rd(etc_pkg::REG_CHAN_A_CTRL, v);
		check(v, 8'hfd);
		wr(etc_pkg::REG_CHAN_B_CTRL, 8'hff);
		rd(etc_pkg::REG_CHAN_B_CTRL, v);
		check(v, 8'hff);
		wr(4'h1, 8'h00);
		wr(4'h2, 8'h00);
		wr(etc_pkg::REG_CMP_A_HI, 8'hff);
		rd(etc_pkg::REG_CMP_A_HI, v);
		check(v, 8'h03);
		wr(etc_pkg::REG_CMP_A_HI, 8'h00);
		wr(etc_pkg::REG_COUNT_HI, 8'hff);
		rd(etc_pkg::REG_COUNT_HI, v);
		check(v, 8'h00);
	endtask : t_regs

	task automatic t_count;
		wr(4'h0, 8'h08);
		cyc(60);
		wr(4'h0, 8'h00);
		rd(4'h3, v);
		cyc(20);
		rd(4'h3, u);
		check(u, v);
		check(8'(v inside {[8'h37:8'h4b]}), 8'h01);
		wr(4'h0, 8'h08);
		rd(4'h3, v);
		check(8'(v < 8'h06), 8'h01);
		wr(4'h0, 8'h88);
		rd(4'h3, v);
		cyc(10);
		rd(4'h3, u);
		check(u, v);
		wr(4'h0, 8'h08);
		rd(4'h3, u);
		check(8'((u - v) inside {[8'h01:8'h08]}), 8'h01);
	endtask : t_count

	task automatic t_period;
		logic [2:0] code [5] = '{3'h1, 3'h4, 3'h7, 3'h0, 3'h0};
		int         w [5]    = '{300, 600, 950, 600, 1100};
		logic [7:0] hi [5]   = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
		for (int i = 0; i < 5; i++)
		begin
			wr(4'h0, 8'h00);
			wr(4'h0, {5'h01, code[i]});
			cyc(w[i]);
			rd(4'h4, v);
			check(v, hi[i]);
		end
		wr(4'h0, 8'h00);
		wr(4'h5, 8'h64);
		wr(4'h7, 8'h0a);
		wr(4'h1, 8'h01);
		wr(4'h0, 8'h08);
		cyc(250);
		rd(4'h3, v);
		check(8'(v inside {[8'h14:8'h5a]}), 8'h01);
		for (int m = 1; m < 3; m++)
		begin
			wr(4'h0, 8'h00);
			wr(4'h1, {2'(m), 6'h01});
			wr(4'h2, {2'(m), 6'h00});
			wr(4'h0, 8'h08);
			cyc(200);
			rd(4'h3, v);
			check(8'(v > 8'h96), 8'h01);
		end
	endtask : t_period

	task automatic t_compare;
		wr(4'h5, 8'h14);
		wr(4'h7, 8'h28);
		for (int i = 0; i < 8; i++)
		begin
			f  = 2'(i);
			lv = i[2];
			wr(4'h0, 8'h00);
			wr(4'h1, {2'h0, f, lv, 3'h0});
			wr(4'h2, {2'h0, f, lv, 3'h4});
			wr(4'h0, 8'h09);
			cyc(4);
			check({6'h0, b_line, a_line}, {6'h0, ~lv, lv});
			cyc(26);
			u = {7'h0, (f == 2'h0) ? lv : (f == 2'h3) ? ~lv : f[1]};
			check({7'h0, a_line}, u);
			check({7'h0, b_line}, {7'h0, ~lv});
			cyc(30);
			check({7'h0, b_line}, u ^ 8'h01);
		end
	endtask : t_compare

	task automatic t_modes;
		for (int m = 0; m < 4; m++)
		begin
			wr(4'h0, 8'h00);
			wr(4'h1, {2'(m), 6'h08});
			wr(4'h2, {2'(m), 6'h08});
			wr(4'h0, 8'h09);
			cyc(5);
			check({4'h0, b_oe, a_oe, b_o, a_o}, {4'h0, {2{~m[0]}}, {2{m == 0}}});
		end
	endtask : t_modes

	task automatic t_pwm;
		int na;
		int nb;
		int dlo [4] = '{62, 30, 157, 62};
		int dhi [4] = '{67, 34, 161, 66};
		for (int i = 0; i < 8; i++)
		begin
			wr(4'h0, 8'h00);
			wr(4'h1, {2'h2, 1'b0, i[0], i[1], i[2], 2'h0});
			wr(4'h2, {2'h2, 1'b0, i[0], i[1], i[2], 2'h0});
			wr(4'h0, 8'h09);
			cyc(5);
			lv = (i[0] ? i[1] : ~i[1]) ^ i[2];
			check({6'h0, b_line, a_line}, {6'h0, lv, lv});
		end
		wr(4'h0, 8'h00);
		wr(4'h5, 8'h20);
		wr(4'h7, 8'h40);
		wr(4'h1, 8'ha8);
		wr(4'h2, 8'ha8);
		wr(4'h0, 8'h09);
		cyc(10);
		na = 0;
		nb = 0;
		repeat (128)
		begin
			cyc(1);
			na += a_line;
			nb += b_line;
		end
		check(8'(na inside {[30:34]}), 8'h01);
		check(8'(nb inside {[62:66]}), 8'h01);
		for (int al = 0; al < 4; al++)
		begin
			wr(4'h0, 8'h00);
			wr(4'h2, {6'h2a, 2'(al)});
			wr(4'h0, 8'h09);
			u = 8'h00;
			repeat (100)
			begin
				rd(4'h1, v);
				u = u | v;
			end
			check(u & 8'h02, {6'h0, al != 0, 1'b0});
			// one full centre period is 254 counts, so the high count is exact there
			na = 0;
			repeat (254)
			begin
				cyc(1);
				na += a_line;
			end
			check(8'(na inside {[dlo[al]:dhi[al]]}), 8'h01);
		end
		wr(4'h0, 8'h00);
		wr(4'h5, 8'h1e);
		wr(4'h1, 8'hb8);
		wr(4'h2, 8'hb8);
		wr(4'h0, 8'h08);
		cyc(10);
		check({7'h0, a_line}, 8'h01);
		cyc(40);
		rd(4'h0, v);
		check(v & 8'h08, 8'h00);
		check({7'h0, a_line}, 8'h00);
	endtask : t_pwm

	task automatic t_capture;
		logic [7:0] lo [4] = '{8'h26, 8'h44, 8'h44, 8'h00};
		logic [7:0] hi [4] = '{8'h32, 8'h50, 8'h50, 8'h00};
		for (int c = 0; c < 4; c++)
		begin
			wr(4'h0, 8'h00);
			wr(4'h1, {2'h1, 2'(c), 4'h0});
			wr(4'h2, {2'h1, 2'(c), 4'h0});
			for (int r = 5; r < 9; r++)
				wr(4'(r), 8'h00);
			wr(4'h0, 8'h08);
			cyc(40);
			ext_a <= 1'b1;
			ext_b <= 1'b1;
			cyc(30);
			ext_a <= 1'b0;
			ext_b <= 1'b0;
			cyc(20);
			rd(4'h5, v);
			check(8'(v inside {[lo[c]:hi[c]]}), 8'h01);
			rd(4'h7, v);
			check(8'(v inside {[lo[c]:hi[c]]}), 8'h01);
		end
	endtask : t_capture

	// reset in mid-run must bring registers and pins back to their idle state
	task automatic t_reset;
		wr(4'h0, 8'h00);
		wr(4'h1, 8'h08);
		wr(4'h2, 8'h08);
		wr(4'h0, 8'h09);
		cyc(5);
		check({4'h0, b_oe, a_oe, b_o, a_o}, 8'h0f);
		reset_i <= 1'b1;
		cyc(3);
		check({4'h0, b_oe, a_oe, b_o, a_o}, 8'h00);
		reset_i <= 1'b0;
		cyc(1);
		check({4'h0, b_oe, a_oe, b_o, a_o}, 8'h0c);
		for (int i = 0; i < 5; i++)
		begin
			rd(4'(i), v);
			check(v, etc_pkg::CTRL_RESET);
		end
	endtask : t_reset

	task automatic final_report;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report

	initial
	begin
		repeat (20) @(posedge mclk_i);
		reset_i <= 1'b0;
		@(posedge mclk_i);
		t_regs();
		t_count();
		t_period();
		t_compare();
		t_modes();
		t_pwm();
		t_capture();
		t_reset();
		final_report();
	end

	// the tests take about 7600 cycles; this leaves ample margin
	initial
	begin
		#(25 * 40000);
		errors++;
		final_report();
	end
endmodule : etc_timer_tb
